// *** cie_core.sv ***
`timescale 1ns/1ps
`include "cie_map.svh"
module cie_core #(
  parameter int STACK_DEPTH = 2,
  parameter int PRE_W       = 8
) (
  input  wire logic                core_clk,
  input  wire logic                arst_n,
  input  wire logic [`CIE_IW-1:0]  instr_word,
  input  wire logic                stack_push,
  input  wire logic [8:0]          stack_push_addr,
  input  wire logic                pin_change_event,
  output logic      [8:0]          prog_addr,
  output logic      [7:0]          acc,
  output logic                     carry,
  output logic                     digit_carry,
  output logic                     zero,
  output logic                     timeout_status_n,
  output logic                     powerdown_status_n,
  output logic                     pin_change_wake_flag,
  output logic      [7:0]          direction_reg,
  output logic                     sleeping,
  output logic      [7:0]          watchdog_counter
);

  logic [1:0]       rst_sync_reg;
  logic             rst_n;
  logic [8:0]       pc_reg, pc_next, sub_sum;
  logic [7:0]       acc_reg, acc_next;
  logic             c_reg, c_next, dc_reg, dc_next, z_reg, z_next;
  logic             to_n_reg, to_n_next, pd_n_reg, pd_n_next, wake_reg, wake_next;
  logic [7:0]       dir_reg, dir_next;
  logic             sleep_reg, sleep_next, flush_reg, flush_next;
  logic [7:0]       wdt_reg, wdt_next;
  logic [PRE_W-1:0] pre_reg, pre_next;
  logic [7:0]       file_reg [32], file_next [32];
  logic [8:0]       stk_reg [STACK_DEPTH], stk_next [STACK_DEPTH];
  cie_pkg::cie_op_t op;
  logic [4:0]       fa;
  logic             dbit;
  logic [7:0]       lit, fval, res;
  logic [4:0]       sub_low;
  logic             wr_res, set_z;

  // The asynchronous reset is released through two flops so that release is clean.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  assign fa   = instr_word[4:0];
  assign dbit = instr_word[5];
  assign lit  = instr_word[7:0];
  assign fval = file_reg[fa];

  always_comb begin
    op = cie_pkg::CIE_OP_NONE;
    if (rst_n && !sleep_reg && !flush_reg) begin
      if ((instr_word & `CIE_M_LIT) == `CIE_V_RETLIT) begin
        op = cie_pkg::CIE_OP_RETLIT;
      end else if ((instr_word & `CIE_M_LIT) == `CIE_V_XORLIT) begin
        op = cie_pkg::CIE_OP_XORLIT;
      end else if ((instr_word & `CIE_M_FULL) == `CIE_V_SLEEP) begin
        op = cie_pkg::CIE_OP_SLEEP;
      end else if ((instr_word & `CIE_M_FULL) == `CIE_V_DIRLOAD) begin
        op = cie_pkg::CIE_OP_DIRLOAD;
      end else if ((instr_word & `CIE_M_FILE) == `CIE_V_ROTL) begin
        op = cie_pkg::CIE_OP_ROTL;
      end else if ((instr_word & `CIE_M_FILE) == `CIE_V_ROTR) begin
        op = cie_pkg::CIE_OP_ROTR;
      end else if ((instr_word & `CIE_M_FILE) == `CIE_V_SUB) begin
        op = cie_pkg::CIE_OP_SUB;
      end else if ((instr_word & `CIE_M_FILE) == `CIE_V_SWAP) begin
        op = cie_pkg::CIE_OP_SWAP;
      end else if ((instr_word & `CIE_M_FILE) == `CIE_V_XORF) begin
        op = cie_pkg::CIE_OP_XORF;
      end
    end
  end

  assign sub_sum = {1'b0, fval} + {1'b0, ~acc_reg} + `CIE_PC_ONE;
  assign sub_low = {1'b0, fval[3:0]} + {1'b0, ~acc_reg[3:0]} + 5'h01;
  always_comb begin
    pc_next    = pc_reg;
    acc_next   = acc_reg;
    c_next     = c_reg;
    dc_next    = dc_reg;
    z_next     = z_reg;
    to_n_next  = to_n_reg;
    pd_n_next  = pd_n_reg;
    wake_next  = wake_reg | pin_change_event;
    dir_next   = dir_reg;
    sleep_next = sleep_reg;
    flush_next = 1'b0;
    wdt_next   = wdt_reg;
    pre_next   = pre_reg;
    file_next  = file_reg;
    stk_next   = stk_reg;
    res        = `CIE_RST_BYTE;
    wr_res     = 1'b0;
    set_z      = 1'b0;
    // The core clock keeps running in power-down; sleep_reg holds the pc, watchdog and stack, and only the wake flag still advances while asleep.
    if (!sleep_reg) begin
      // The discard cycle holds the popped address, so the word at the return address runs next.
      pc_next = flush_reg ? pc_reg : pc_reg + `CIE_PC_ONE;
      {wdt_next, pre_next} = {wdt_reg, pre_reg} + (PRE_W + 8)'(1);
      if (stack_push) begin
        for (int i = STACK_DEPTH - 1; i > 0; i--) begin
          stk_next[i] = stk_reg[i-1];
        end
        stk_next[0] = stack_push_addr;
      end
    end
    case (op)
      cie_pkg::CIE_OP_RETLIT: begin
        acc_next = lit;
        pc_next  = stk_reg[0];
        // A pop takes precedence over a push arriving in the same cycle.
        for (int i = 0; i < STACK_DEPTH - 1; i++) begin
          stk_next[i] = stk_reg[i+1];
        end
        flush_next = 1'b1;
      end
      cie_pkg::CIE_OP_SLEEP: begin
        wdt_next   = `CIE_WDT_ZERO;
        pre_next   = '0;
        to_n_next  = 1'b1;
        pd_n_next  = 1'b0;
        sleep_next = 1'b1;
      end
      cie_pkg::CIE_OP_ROTL: begin
        res    = {fval[6:0], c_reg};
        c_next = fval[7];
        wr_res = 1'b1;
      end
      cie_pkg::CIE_OP_ROTR: begin
        res    = {c_reg, fval[7:1]};
        c_next = fval[0];
        wr_res = 1'b1;
      end
      cie_pkg::CIE_OP_SUB: begin
        res     = sub_sum[7:0];
        c_next  = sub_sum[8];
        dc_next = sub_low[4];
        wr_res  = 1'b1;
        set_z   = 1'b1;
      end
      cie_pkg::CIE_OP_SWAP: begin
        res    = {fval[3:0], fval[7:4]};
        wr_res = 1'b1;
      end
      cie_pkg::CIE_OP_DIRLOAD: begin
        dir_next = acc_reg;
      end
      cie_pkg::CIE_OP_XORLIT: begin
        res      = acc_reg ^ lit;
        acc_next = res;
        set_z    = 1'b1;
      end
      cie_pkg::CIE_OP_XORF: begin
        res    = acc_reg ^ fval;
        wr_res = 1'b1;
        set_z  = 1'b1;
      end
      default: begin
      end
    endcase
    if (wr_res) begin
      if (dbit) begin
        file_next[fa] = res;
      end else begin
        acc_next = res;
      end
    end
    if (set_z) begin
      z_next = (res == `CIE_RST_BYTE);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_reg    <= `CIE_RST_PC;
      acc_reg   <= `CIE_RST_BYTE;
      c_reg     <= 1'b0;
      dc_reg    <= 1'b0;
      z_reg     <= 1'b0;
      to_n_reg  <= 1'b1;
      pd_n_reg  <= 1'b1;
      wake_reg  <= 1'b0;
      dir_reg   <= `CIE_RST_DIR;
      sleep_reg <= 1'b0;
      flush_reg <= 1'b0;
      wdt_reg   <= `CIE_WDT_ZERO;
      pre_reg   <= '0;
      for (int i = 0; i < 32; i++) begin
        file_reg[i] <= `CIE_RST_BYTE;
      end
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stk_reg[i] <= `CIE_RST_PC;
      end
    end else begin
      pc_reg    <= pc_next;
      acc_reg   <= acc_next;
      c_reg     <= c_next;
      dc_reg    <= dc_next;
      z_reg     <= z_next;
      to_n_reg  <= to_n_next;
      pd_n_reg  <= pd_n_next;
      wake_reg  <= wake_next;
      dir_reg   <= dir_next;
      sleep_reg <= sleep_next;
      flush_reg <= flush_next;
      wdt_reg   <= wdt_next;
      pre_reg   <= pre_next;
      file_reg  <= file_next;
      stk_reg   <= stk_next;
    end
  end

  assign prog_addr            = pc_reg;
  assign acc                  = acc_reg;
  assign carry                = c_reg;
  assign digit_carry          = dc_reg;
  assign zero                 = z_reg;
  assign timeout_status_n     = to_n_reg;
  assign powerdown_status_n   = pd_n_reg;
  assign pin_change_wake_flag = wake_reg;
  assign direction_reg        = dir_reg;
  assign sleeping             = sleep_reg;
  assign watchdog_counter     = wdt_reg;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  retlit_acc_a: assert property (op == cie_pkg::CIE_OP_RETLIT |=>
    acc_reg == $past(lit) && $stable(c_reg) && $stable(z_reg) && $stable(dc_reg))
    else $error("return literal did not load accumulator or disturbed flags");
  retlit_pop_a: assert property (op == cie_pkg::CIE_OP_RETLIT |=> pc_reg == $past(stk_reg[0]))
    else $error("return literal did not pop the stack into the pc");
  retlit_bubble_a: assert property (op == cie_pkg::CIE_OP_RETLIT |=>
    flush_reg ##1 (!flush_reg && $stable(acc_reg) && $stable(pc_reg)))
    else $error("word after return literal was not discarded");
  sleep_wdt_a: assert property (op == cie_pkg::CIE_OP_SLEEP |=> wdt_reg == 8'h00 && pre_reg == '0)
    else $error("power-down did not clear the watchdog");
  sleep_to_a: assert property (op == cie_pkg::CIE_OP_SLEEP |=> to_n_reg)
    else $error("power-down did not set the time-out bit");
  sleep_pd_a: assert property (op == cie_pkg::CIE_OP_SLEEP |=>
    !pd_n_reg && wake_reg == ($past(wake_reg) | $past(pin_change_event)))
    else $error("power-down bit or wake flag wrong after power-down");
  sleep_halt_a: assert property (sleep_reg |=> sleep_reg && $stable(pc_reg) && $stable(acc_reg))
    else $error("core advanced while halted");
  rotl_res_a: assert property (op == cie_pkg::CIE_OP_ROTL && !dbit |=>
    acc_reg == {$past(fval[6:0]), $past(c_reg)} && c_reg == $past(fval[7]) && $stable(z_reg))
    else $error("rotate left result or carry wrong");
  rotr_res_a: assert property (op == cie_pkg::CIE_OP_ROTR && dbit |=>
    file_reg[$past(fa)] == {$past(c_reg), $past(fval[7:1])} && c_reg == $past(fval[0]))
    else $error("rotate right result or carry wrong");
  sub_flags_a: assert property (op == cie_pkg::CIE_OP_SUB && !dbit |=>
    acc_reg == 8'($past(fval) - $past(acc_reg)) && c_reg == ($past(fval) >= $past(acc_reg))
    && z_reg == ($past(fval) == $past(acc_reg)))
    else $error("subtract result or flags wrong");
  swap_dest_a: assert property (op == cie_pkg::CIE_OP_SWAP && dbit |=>
    file_reg[$past(fa)] == {$past(fval[3:0]), $past(fval[7:4])} && $stable(acc_reg))
    else $error("nibble swap to file wrong");
  dirload_a: assert property (op == cie_pkg::CIE_OP_DIRLOAD |=>
    dir_reg == $past(acc_reg) && $stable(z_reg) && $stable(c_reg))
    else $error("direction load wrong");
  xorlit_a: assert property (op == cie_pkg::CIE_OP_XORLIT |=>
    acc_reg == ($past(acc_reg) ^ $past(lit)) && z_reg == (acc_reg == 8'h00))
    else $error("xor literal wrong");
  xorfile_a: assert property (op == cie_pkg::CIE_OP_XORF && dbit |=>
    file_reg[$past(fa)] == ($past(acc_reg) ^ $past(fval)) && $stable(acc_reg))
    else $error("xor file wrong");
  single_cycle_a: assert property (op != cie_pkg::CIE_OP_NONE && op != cie_pkg::CIE_OP_RETLIT
    && op != cie_pkg::CIE_OP_SLEEP |=> !flush_reg && pc_reg == 9'($past(pc_reg) + 9'h001))
    else $error("single cycle instruction stalled");
endmodule

// *** cie_map.svh ***
`ifndef CIE_MAP_SVH
`define CIE_MAP_SVH

// Instruction word width and opcode match masks and values.
`define CIE_IW          12
`define CIE_M_LIT       12'hF00
`define CIE_M_FILE      12'hFC0
`define CIE_M_FULL      12'hFFF
`define CIE_V_RETLIT    12'h800
`define CIE_V_XORLIT    12'hF00
`define CIE_V_SLEEP     12'h003
`define CIE_V_DIRLOAD   12'h006
`define CIE_V_ROTL      12'h340
`define CIE_V_ROTR      12'h300
`define CIE_V_SUB       12'h080
`define CIE_V_SWAP      12'h380
`define CIE_V_XORF      12'h180

// Reset values and the pc increment.
`define CIE_RST_PC      9'h000
`define CIE_RST_BYTE    8'h00
`define CIE_RST_DIR     8'hFF
`define CIE_PC_ONE      9'h001
`define CIE_WDT_ZERO    8'h00

`endif

// *** cie_pkg.sv ***
package cie_pkg;
  typedef enum logic [3:0] {
    CIE_OP_NONE, CIE_OP_RETLIT, CIE_OP_SLEEP, CIE_OP_ROTL, CIE_OP_ROTR,
    CIE_OP_SUB, CIE_OP_SWAP, CIE_OP_DIRLOAD, CIE_OP_XORLIT, CIE_OP_XORF
  } cie_op_t;
endpackage

// *** cie_prog_mem.sv ***
`timescale 1ns/1ps
`include "cie_map.svh"
module cie_prog_mem (
  input  wire logic [8:0]         prog_addr,
  output logic      [`CIE_IW-1:0] instr_word
);
  // The bench clears every word to the no-op encoding, so a runaway fetch does no harm.
  logic [`CIE_IW-1:0] rom [0:511];
  always_comb begin
    instr_word = rom[prog_addr];
  end
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
`include "cie_map.svh"
module tb_top;
  logic              core_clk;
  logic              arst_n;
  logic [`CIE_IW-1:0] instr_word;
  logic              stack_push;
  logic [8:0]        stack_push_addr;
  logic              pin_change_event;
  logic [8:0]        prog_addr;
  logic [7:0]        acc;
  logic              carry;
  logic              digit_carry;
  logic              zero;
  logic              timeout_status_n;
  logic              powerdown_status_n;
  logic              pin_change_wake_flag;
  logic [7:0]        direction_reg;
  logic              sleeping;
  logic [7:0]        watchdog_counter;
  int                num_errors;
  int                checks;
  int                n;
  logic [8:0]        pc_hold;

  cie_core uut (.core_clk(core_clk), .arst_n(arst_n), .instr_word(instr_word),
    .stack_push(stack_push), .stack_push_addr(stack_push_addr),
    .pin_change_event(pin_change_event), .prog_addr(prog_addr), .acc(acc),
    .carry(carry), .digit_carry(digit_carry), .zero(zero),
    .timeout_status_n(timeout_status_n), .powerdown_status_n(powerdown_status_n),
    .pin_change_wake_flag(pin_change_wake_flag), .direction_reg(direction_reg),
    .sleeping(sleeping), .watchdog_counter(watchdog_counter));
  cie_prog_mem mem (.prog_addr(prog_addr), .instr_word(instr_word));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp1(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic load(input logic [`CIE_IW-1:0] w [8]);
    for (int i = 0; i < 512; i++) begin
      mem.rom[i] = 12'h000;
    end
    for (int i = 0; i < 8; i++) begin
      mem.rom[i] = w[i];
    end
  endtask

  // The push lands on the first executing edge, the third after reset is let go.
  task automatic start(input logic push, input logic [8:0] ret);
    @(negedge core_clk);
    arst_n = 1'b0;
    repeat (5) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    stack_push = push;
    stack_push_addr = ret;
    @(negedge core_clk);
    stack_push = 1'b0;
  endtask

  task automatic wait_sleep(output int cyc);
    cyc = 0;
    while (sleeping !== 1'b1) begin
      @(negedge core_clk);
      cyc++;
      if (cyc > 400) begin
        num_errors++;
        $display("mismatch sleep entry expected 1 seen %b", sleeping);
        give_verdict();
      end
    end
  endtask

  task automatic t_return_with_literal();
    load('{12'hF00, 12'h8A5, 12'hFFF, 12'h000, `CIE_V_SLEEP, 12'h000, 12'h000, 12'h000});
    mem.rom[32] = `CIE_V_SLEEP;
    start(1'b1, 9'h020);
    wait_sleep(n);
    cmp8("return_with_literal acc", 8'hA5, acc);
    cmp1("return_with_literal zero", 1'b1, zero);
    cmp8("return_with_literal cycles", 8'h03, n[7:0]);
    $display("test return_with_literal done");
  endtask

  task automatic t_sleep();
    load('{12'h000, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000});
    mem.rom[300] = `CIE_V_SLEEP;
    mem.rom[301] = 12'hFFF;
    start(1'b0, 9'h000);
    cmp8("direction reset", 8'hFF, direction_reg);
    cmp1("wake flag reset", 1'b0, pin_change_wake_flag);
    pin_change_event = 1'b1;
    @(negedge core_clk);
    pin_change_event = 1'b0;
    repeat (270) @(negedge core_clk);
    cmp8("watchdog awake", 8'h01, watchdog_counter);
    wait_sleep(n);
    cmp8("sleep cycles", 8'h1D, n[7:0]);
    cmp8("watchdog cleared", 8'h00, watchdog_counter);
    cmp1("timeout bit", 1'b1, timeout_status_n);
    cmp1("powerdown bit", 1'b0, powerdown_status_n);
    cmp1("wake flag kept", 1'b1, pin_change_wake_flag);
    pc_hold = prog_addr;
    repeat (20) @(negedge core_clk);
    cmp8("pc frozen", pc_hold[7:0], prog_addr[7:0]);
    cmp8("acc frozen", 8'h00, acc);
    cmp8("watchdog halted", 8'h00, watchdog_counter);
    $display("test sleep done");
  endtask

  task automatic t_rot();
    load('{12'hF81, 12'h1A5, 12'hF81, 12'h365, 12'h325, 12'h305, 12'h345, `CIE_V_SLEEP});
    start(1'b0, 9'h000);
    wait_sleep(n);
    cmp8("rotate acc", 8'h03, acc);
    cmp1("rotate carry", 1'b1, carry);
    cmp1("rotate zero", 1'b1, zero);
    cmp8("rotate cycles", 8'h07, n[7:0]);
    $display("test rotate done");
  endtask

  task automatic t_sub(input logic [7:0] f, input logic [7:0] a);
    logic [7:0] r;
    r = f - a;
    load('{12'hF00 | f, 12'h1A7, 12'hF00 | (f ^ a), 12'h087, `CIE_V_SLEEP,
           12'h000, 12'h000, 12'h000});
    start(1'b0, 9'h000);
    wait_sleep(n);
    cmp8("sub acc", r, acc);
    cmp1("sub carry", f >= a, carry);
    cmp1("sub digit carry", f[3:0] >= a[3:0], digit_carry);
    cmp1("sub zero", r == 8'h00, zero);
    cmp8("sub cycles", 8'h04, n[7:0]);
  endtask

  task automatic t_swap();
    load('{12'hF3C, 12'h1A9, 12'hF3C, 12'h3A9, 12'h389, `CIE_V_DIRLOAD, `CIE_V_SLEEP,
           12'h000});
    start(1'b0, 9'h000);
    wait_sleep(n);
    cmp8("swap acc", 8'h3C, acc);
    cmp1("swap zero", 1'b1, zero);
    cmp8("direction", 8'h3C, direction_reg);
    cmp8("swap cycles", 8'h06, n[7:0]);
    $display("test swap done");
  endtask

  task automatic t_xor();
    load('{12'hF5A, 12'h1A3, 12'hF55, 12'h1A3, 12'hF5A, 12'h183, `CIE_V_SLEEP, 12'h000});
    start(1'b0, 9'h000);
    wait_sleep(n);
    cmp8("xor acc", 8'h00, acc);
    cmp1("xor zero", 1'b1, zero);
    cmp8("xor cycles", 8'h06, n[7:0]);
    $display("test xor done");
  endtask

  initial begin
    arst_n = 1'b0;
    stack_push = 1'b0;
    stack_push_addr = 9'h000;
    pin_change_event = 1'b0;
    num_errors = 0;
    checks = 0;
    t_return_with_literal();
    t_sleep();
    t_rot();
    t_sub(8'h10, 8'h01);
    t_sub(8'h33, 8'h33);
    t_sub(8'h01, 8'h02);
    t_sub(8'hFF, 8'h00);
    $display("test subtract done");
    t_swap();
    t_xor();
    give_verdict();
  end
endmodule
